// File: adc_control.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "adc_consts.svh"
module adc_control
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave, word addressed
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // analog core, same clock
    output logic      [4:0]  input_select_o,
    output logic             sample_open_o,
    output logic             convert_start_o,
    input  wire logic        convert_done_i,
    input  wire logic [9:0]  convert_data_i,
    // event and debug pins, asynchronous
    input  wire logic        start_event_i,
    input  wire logic        debug_halt_i,
    // interrupt requests
    output logic             ready_irq_o,
    output logic             window_irq_o
);

    // ------------------------------------------------------------
    // reset and pin synchronisers
    // ------------------------------------------------------------
    logic       rst_meta_reg;
    logic       rst_n_reg;
    logic [1:0] event_sync_reg;
    logic [1:0] halt_sync_reg;
    logic       event_last_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            event_sync_reg <= 2'h0;
            halt_sync_reg  <= 2'h0;
            event_last_reg <= 1'b0;
        end
        else
        begin
            event_sync_reg <= {event_sync_reg[0], start_event_i};
            halt_sync_reg  <= {halt_sync_reg[0], debug_halt_i};
            event_last_reg <= event_sync_reg[1];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  main_reg;
    logic [2:0]  accum_code_reg;
    logic [2:0]  prescale_reg;
    logic [7:0]  delay_ctrl_reg;
    logic [2:0]  window_mode_reg;
    logic [4:0]  sample_length_reg;
    logic [4:0]  input_select_reg;
    logic        event_start_enable_reg;
    logic [1:0]  int_enable_reg;
    logic [1:0]  flags_reg;
    logic        run_when_halted_reg;
    logic [7:0]  staging_reg;
    logic [15:0] result_reg;
    logic [15:0] win_low_reg;
    logic [15:0] win_high_reg;
    logic        busy_reg;
    logic        wait_reg;

    wire bus_req  = avs_read_i | avs_write_i;
    wire bus_take = bus_req & ~wait_reg;
    wire wr       = avs_write_i & bus_take;
    wire rd       = avs_read_i & bus_take;
    wire [7:0] wdat = avs_writedata_i[7:0];

    wire enabled  = main_reg[`BIT_ENABLE];
    wire halted   = halt_sync_reg[1] & ~run_when_halted_reg;
    wire ev_edge  = event_sync_reg[1] & ~event_last_reg;
    wire ev_start = ev_edge & event_start_enable_reg & ~halted;
    wire sw_start = wr && avs_address_i == `IDX_COMMAND && wdat[`BIT_START];
    wire auto_restart;
    wire start    = enabled & (~busy_reg | auto_restart) & (sw_start | ev_start | auto_restart);

    wire res_read = rd && avs_address_i == `IDX_RESULT_LO;
    wire flag_wr  = wr && avs_address_i == `IDX_INT_FLAGS;
    wire [1:0] flag_clr = ({2{flag_wr}} & wdat[1:0]) | {2{res_read}};

    // ------------------------------------------------------------
    // converter clock enable
    // ------------------------------------------------------------
    logic [7:0] div_reg;
    wire [7:0] div_mask = 8'(({1'b0, 8'hFF} >> (3'h7 - prescale_reg)) & 9'h0FF);
    wire tick = ((div_reg & div_mask) == div_mask) & ~halted;

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            div_reg <= 8'h00;
        else if (!enabled)
            div_reg <= 8'h00;
        else
            div_reg <= div_reg + 8'h01;
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    adc_pkg::conv_state_e state_reg;
    adc_pkg::conv_state_e state_next;
    logic [5:0]  count_reg;
    logic [5:0]  samples_reg;
    logic [15:0] acc_reg;
    logic [4:0]  held_select_reg;
    logic        convert_reg;

    wire [6:0] samples_needed = 7'h01 << accum_code_reg;
    wire       last_sample    = {1'b0, samples_reg} + 7'h01 >= samples_needed;
    wire [9:0] sample_val     = main_reg[`BIT_RESOLUTION] ?
                                {2'h0, convert_data_i[9:2]} : convert_data_i;
    wire [15:0] acc_sum       = acc_reg + {6'h00, sample_val};
    wire [5:0] sample_cycles  = `BASE_SAMPLE_CYCLES + {1'b0, sample_length_reg};
    wire [5:0] delay_cycles   = {2'h0, delay_ctrl_reg[3:0]};
    wire       delay_over     = count_reg >= delay_cycles;
    wire       sample_over    = count_reg + 6'h01 >= sample_cycles;
    wire       conv_finished  = state_reg == adc_pkg::ST_DONE;
    assign auto_restart = conv_finished & main_reg[`BIT_CONTINUOUS];

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            adc_pkg::ST_IDLE:
                if (start)
                    state_next = adc_pkg::ST_DELAY;
            adc_pkg::ST_DELAY:
                if (tick && delay_over)
                    state_next = adc_pkg::ST_SAMPLE;
            adc_pkg::ST_SAMPLE:
                if (tick && sample_over)
                    state_next = adc_pkg::ST_CONVERT;
            adc_pkg::ST_CONVERT:
                if (convert_done_i)
                    state_next = last_sample ? adc_pkg::ST_DONE : adc_pkg::ST_DELAY;
            adc_pkg::ST_DONE:
                state_next = start ? adc_pkg::ST_DELAY : adc_pkg::ST_IDLE;
            default:
                state_next = adc_pkg::ST_IDLE;
        endcase
        if (!enabled)
            state_next = adc_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            state_reg <= adc_pkg::ST_IDLE;
        else if (!halted)
            state_reg <= state_next;
    end

    // the phase counter only advances on the converter tick
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            count_reg <= 6'h00;
        else if (!enabled || state_next != state_reg)
            count_reg <= 6'h00;
        else if (tick && (state_reg == adc_pkg::ST_DELAY || state_reg == adc_pkg::ST_SAMPLE))
            count_reg <= count_reg + 6'h01;
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            samples_reg     <= 6'h00;
            acc_reg         <= `RESET_WORD;
            held_select_reg <= 5'h00;
        end
        else if (start && !halted)
        begin
            samples_reg     <= 6'h00;
            acc_reg         <= `RESET_WORD;
            held_select_reg <= input_select_reg;
        end
        else if (state_reg == adc_pkg::ST_CONVERT && convert_done_i && !halted)
        begin
            samples_reg <= samples_reg + 6'h01;
            acc_reg     <= acc_sum;
        end
    end

    // pulse the analog core once per sample
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            convert_reg <= 1'b0;
        else
            convert_reg <= ~halted & tick & sample_over & (state_reg == adc_pkg::ST_SAMPLE);
    end

    // ------------------------------------------------------------
    // window comparator on the finished sum
    // ------------------------------------------------------------
    wire below = acc_reg < win_low_reg;
    wire above = acc_reg > win_high_reg;
    logic win_hit;
    always_comb
    begin
        case (window_mode_reg)
            adc_pkg::WIN_BELOW:   win_hit = below;
            adc_pkg::WIN_ABOVE:   win_hit = above;
            adc_pkg::WIN_INSIDE:  win_hit = (acc_reg > win_low_reg) & (acc_reg < win_high_reg);
            adc_pkg::WIN_OUTSIDE: win_hit = below | above;
            default:              win_hit = 1'b0;
        endcase
    end

    wire [1:0] flag_set = {conv_finished & win_hit, conv_finished};
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wire var_step = main_reg[`BIT_ENABLE] & delay_ctrl_reg[`BIT_DELAY_VARIATION] &
                    (state_reg == adc_pkg::ST_CONVERT) & convert_done_i & ~halted;

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            main_reg               <= `RESET_BYTE;
            accum_code_reg         <= 3'h0;
            prescale_reg           <= 3'h0;
            delay_ctrl_reg         <= `RESET_BYTE;
            window_mode_reg        <= 3'h0;
            sample_length_reg      <= 5'h00;
            input_select_reg       <= 5'h00;
            event_start_enable_reg <= 1'b0;
            int_enable_reg         <= 2'h0;
            run_when_halted_reg    <= 1'b0;
            win_low_reg            <= `RESET_WORD;
            win_high_reg           <= `RESET_WORD;
        end
        else
        begin
            if (wr)
            begin
                case (avs_address_i)
                    `IDX_MAIN_CONTROL:  main_reg               <= {5'h00, wdat[2:0]};
                    `IDX_ACCUM_CONTROL: accum_code_reg         <= wdat[2:0];
                    `IDX_CLOCK_CONTROL: prescale_reg           <= wdat[2:0];
                    `IDX_DELAY_CONTROL: delay_ctrl_reg         <= {3'h0, wdat[4:0]};
                    `IDX_WINDOW_MODE:   window_mode_reg        <= wdat[2:0];
                    `IDX_SAMPLE_LENGTH: sample_length_reg      <= wdat[4:0];
                    `IDX_INPUT_SELECT:  input_select_reg       <= wdat[4:0];
                    `IDX_EVENT_CONTROL: event_start_enable_reg <= wdat[`BIT_EVENT_START];
                    `IDX_INT_ENABLE:    int_enable_reg         <= wdat[1:0];
                    `IDX_DEBUG_CONTROL: run_when_halted_reg    <= wdat[`BIT_RUN_WHEN_HALTED];
                    `IDX_WIN_LOW_LO:    win_low_reg[7:0]       <= wdat;
                    `IDX_WIN_LOW_HI:    win_low_reg            <= {wdat, staging_reg};
                    `IDX_WIN_HIGH_LO:   win_high_reg[7:0]      <= wdat;
                    `IDX_WIN_HIGH_HI:   win_high_reg           <= {wdat, staging_reg};
                    default:            ;
                endcase
            end
            // hardware step wins over a same-cycle software write
            if (var_step)
                delay_ctrl_reg[3:0] <= delay_ctrl_reg[3:0] == `DELAY_WRAP_MAX ?
                                       4'h0 : delay_ctrl_reg[3:0] + 4'h1;
        end
    end

    // staging byte: written directly, low-byte writes, and high byte on low read
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            staging_reg <= `RESET_BYTE;
        else if (wr && (avs_address_i == `IDX_STAGING || avs_address_i == `IDX_WIN_LOW_LO ||
                        avs_address_i == `IDX_WIN_HIGH_LO))
            staging_reg <= wdat;
        else if (rd && avs_address_i == `IDX_RESULT_LO)
            staging_reg <= result_reg[15:8];
        else if (rd && avs_address_i == `IDX_WIN_LOW_LO)
            staging_reg <= win_low_reg[15:8];
        else if (rd && avs_address_i == `IDX_WIN_HIGH_LO)
            staging_reg <= win_high_reg[15:8];
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            flags_reg  <= 2'h0;
            result_reg <= `RESET_WORD;
            busy_reg   <= 1'b0;
        end
        else
        begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
            if (conv_finished)
                result_reg <= acc_reg;
            if (!enabled)
                busy_reg <= 1'b0;
            else if (start && !halted)
                busy_reg <= 1'b1;
            else if (conv_finished)
                busy_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus answer: one wait cycle, data registered
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb
    begin
        case (avs_address_i)
            `IDX_MAIN_CONTROL:  rd_byte = main_reg;
            `IDX_ACCUM_CONTROL: rd_byte = {5'h00, accum_code_reg};
            `IDX_CLOCK_CONTROL: rd_byte = {5'h00, prescale_reg};
            `IDX_DELAY_CONTROL: rd_byte = delay_ctrl_reg;
            `IDX_WINDOW_MODE:   rd_byte = {5'h00, window_mode_reg};
            `IDX_SAMPLE_LENGTH: rd_byte = {3'h0, sample_length_reg};
            `IDX_INPUT_SELECT:  rd_byte = {3'h0, input_select_reg};
            `IDX_COMMAND:       rd_byte = {7'h00, busy_reg};
            `IDX_EVENT_CONTROL: rd_byte = {7'h00, event_start_enable_reg};
            `IDX_INT_ENABLE:    rd_byte = {6'h00, int_enable_reg};
            `IDX_INT_FLAGS:     rd_byte = {6'h00, flags_reg};
            `IDX_DEBUG_CONTROL: rd_byte = {7'h00, run_when_halted_reg};
            `IDX_STAGING:       rd_byte = staging_reg;
            `IDX_RESULT_LO:     rd_byte = result_reg[7:0];
            `IDX_RESULT_HI:     rd_byte = staging_reg;
            `IDX_WIN_LOW_LO:    rd_byte = win_low_reg[7:0];
            `IDX_WIN_LOW_HI:    rd_byte = staging_reg;
            `IDX_WIN_HIGH_LO:   rd_byte = win_high_reg[7:0];
            `IDX_WIN_HIGH_HI:   rd_byte = staging_reg;
            default:            rd_byte = 8'h00;
        endcase
    end

    logic [31:0] readdata_reg;
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            wait_reg     <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= ~(bus_req & wait_reg);
            if (avs_read_i && wait_reg)
                readdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [1:0] irq_reg;
    logic       open_reg;
    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            irq_reg  <= 2'h0;
            open_reg <= 1'b0;
        end
        else
        begin
            irq_reg  <= flags_reg & int_enable_reg;
            // cap stays open through delay and sample phases
            open_reg <= state_next == adc_pkg::ST_DELAY || state_next == adc_pkg::ST_SAMPLE;
        end
    end

    assign avs_readdata_o    = readdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign input_select_o    = held_select_reg;
    assign sample_open_o     = open_reg;
    assign convert_start_o   = convert_reg;
    assign ready_irq_o       = irq_reg[`BIT_RESULT_READY];
    assign window_irq_o      = irq_reg[`BIT_WINDOW_MATCH];

endmodule

// File: adc_consts.svh
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// register indexes; byte address is four times the index
`define IDX_MAIN_CONTROL      5'h00
`define IDX_ACCUM_CONTROL     5'h01
`define IDX_CLOCK_CONTROL     5'h02
`define IDX_DELAY_CONTROL     5'h03
`define IDX_WINDOW_MODE       5'h04
`define IDX_SAMPLE_LENGTH     5'h05
`define IDX_INPUT_SELECT      5'h06
`define IDX_COMMAND           5'h08
`define IDX_EVENT_CONTROL     5'h09
`define IDX_INT_ENABLE        5'h0A
`define IDX_INT_FLAGS         5'h0B
`define IDX_DEBUG_CONTROL     5'h0C
`define IDX_STAGING           5'h0D
`define IDX_RESULT_LO         5'h10
`define IDX_RESULT_HI         5'h11
`define IDX_WIN_LOW_LO        5'h12
`define IDX_WIN_LOW_HI        5'h13
`define IDX_WIN_HIGH_LO       5'h14
`define IDX_WIN_HIGH_HI       5'h15

// field positions
`define BIT_ENABLE            0
`define BIT_CONTINUOUS        1
`define BIT_RESOLUTION        2
`define BIT_DELAY_VARIATION   4
`define BIT_START             0
`define BIT_EVENT_START       0
`define BIT_RESULT_READY      0
`define BIT_WINDOW_MATCH      1
`define BIT_RUN_WHEN_HALTED   0

// reset values and timing counts
`define RESET_BYTE            8'h00
`define RESET_WORD            16'h0000
`define BASE_SAMPLE_CYCLES    6'h02
`define DELAY_WRAP_MAX        4'hF

`endif

// File: adc_pkg.sv
package adc_pkg;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_DELAY   = 5'b00010,
        ST_SAMPLE  = 5'b00100,
        ST_CONVERT = 5'b01000,
        ST_DONE    = 5'b10000
    } conv_state_e;

    typedef enum logic [2:0] {
        WIN_NONE    = 3'h0,
        WIN_BELOW   = 3'h1,
        WIN_ABOVE   = 3'h2,
        WIN_INSIDE  = 3'h3,
        WIN_OUTSIDE = 3'h4
    } window_mode_e;

endpackage

// File: adc_control_properties.sv
`timescale 1ns/1ns
module adc_control_properties
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // register bus
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // analog core and interrupts
    input wire logic [4:0]  input_select_o,
    input wire logic        sample_open_o,
    input wire logic        convert_start_o,
    input wire logic        ready_irq_o,
    input wire logic        window_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest did not drop");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_read_byte: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:8] == 24'h000000) else $error("readdata upper bits set");
    a_start_pulse: assert property (convert_start_o |=> !convert_start_o)
        else $error("convert start longer than one cycle");
    a_sample_before: assert property ($rose(convert_start_o) |-> $past(sample_open_o))
        else $error("convert requested without sampling");
    a_sample_min: assert property ($rose(sample_open_o) |-> sample_open_o[*3])
        else $error("sampling phase too short");
    a_select_held: assert property (sample_open_o && $past(sample_open_o)
        |-> $stable(input_select_o)) else $error("input select changed mid conversion");
    a_flags_clear: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == 5'h10 |-> ##[1:3] (!ready_irq_o && !window_irq_o))
        else $error("result read left a request raised");

    c_convert: cover property ($rose(convert_start_o));
    c_ready: cover property ($rose(ready_irq_o));
    c_window: cover property ($rose(window_irq_o));
endmodule

// File: adc_core_model.sv
`timescale 1ns/1ns
module adc_core_model
(
    // clock and design side
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [4:0]  select_i,
    output logic             done_o,
    output logic      [9:0]  data_o,
    // bench side
    input  wire logic [9:0]  level_i,
    input  wire logic [3:0]  lat_i,
    output logic      [4:0]  seen_o,
    output logic      [15:0] count_o
);
    logic [3:0] wait_cnt = 4'h0;
    initial
    begin
        done_o = 1'b0;
        data_o = 10'h000;
        seen_o = 5'h00;
        count_o = 16'h0000;
    end
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        // outside done the line toggles so a stale sample is never read
        data_o <= ~data_o;
        if (start_i)
        begin
            wait_cnt <= lat_i;
            seen_o <= select_i;
            count_o <= count_o + 16'h0001;
        end
        else if (wait_cnt == 4'h1)
        begin
            wait_cnt <= 4'h0;
            done_o <= 1'b1;
            data_o <= level_i;
        end
        else if (wait_cnt > 4'h1)
            wait_cnt <= wait_cnt - 4'h1;
    end
endmodule

// File: tb_adc_control.sv
`timescale 1ns/1ns
module tb_adc_control;
    logic        clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0]  avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o, sample_open_o, convert_start_o, convert_done_i;
    logic        start_event_i = 1'b0, debug_halt_i = 1'b0, ready_irq_o, window_irq_o;
    logic [4:0]  input_select_o, seen;
    logic [9:0]  convert_data_i, level = 10'h000;
    logic [3:0]  lat = 4'h1;
    logic [15:0] count;
    int          errors = 0, comparisons = 0, cycles = 0;

    adc_control i_adc_control (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .input_select_o(input_select_o), .sample_open_o(sample_open_o),
        .convert_start_o(convert_start_o), .convert_done_i(convert_done_i),
        .convert_data_i(convert_data_i), .start_event_i(start_event_i),
        .debug_halt_i(debug_halt_i), .ready_irq_o(ready_irq_o), .window_irq_o(window_irq_o));
    adc_core_model i_adc_core_model (.clk_i(clk_i), .start_i(convert_start_o),
        .select_i(input_select_o), .done_o(convert_done_i), .data_o(convert_data_i),
        .level_i(level), .lat_i(lat), .seen_o(seen), .count_o(count));

    // ----------------
    // tasks
    // ----------------
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        int n = 0;
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h000000, d};
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0)
        begin
            n++;
            @(posedge clk_i);
        end
        q = avs_readdata_o[7:0];
        chk(16'(n), 16'h0001);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        bus(a, 1'b0, 8'h00, q);
    endtask
    task automatic wait_idle(input logic busy_check);
        logic [7:0] q;
        int n = 0;
        rd(5'h08, q);
        if (busy_check)
            chk(q[0], 1'b1);
        while (q[0] !== 1'b0 && n < 3000)
        begin
            rd(5'h08, q);
            n++;
        end
        chk(q[0], 1'b0);
    endtask
    task automatic conv();
        wr(5'h08, 8'h01);
        wait_idle(1'b1);
    endtask
    task automatic pulse();
        @(posedge clk_i);
        start_event_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        start_event_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        logic [4:0] idx [12] = '{5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
                                 5'h0D, 5'h10, 5'h11, 5'h07};
        logic [7:0] q;
        wr(5'h07, 8'hFF);
        foreach (idx[i])
        begin
            rd(idx[i], q);
            chk(q, 8'h00);
        end
        wr(5'h0D, 8'h5A);
        rd(5'h0D, q);
        chk(q, 8'h5A);
        wr(5'h00, 8'h01);
        wr(5'h05, 8'h04);
        $display("t_regs done");
    endtask
    task automatic t_window();
        logic [9:0] v [4] = '{10'h0FF, 10'h100, 10'h155, 10'h201};
        logic [7:0] q;
        logic       e;
        wr(5'h12, 8'h00);
        wr(5'h13, 8'h01);
        wr(5'h14, 8'h00);
        wr(5'h15, 8'h02);
        for (int m = 0; m < 5; m++)
            for (int k = 0; k < 4; k++)
            begin
                e = m == 1 ? v[k] < 10'h100 : m == 2 ? v[k] > 10'h200 :
                    m == 3 ? v[k] > 10'h100 && v[k] < 10'h200 :
                    m == 4 ? v[k] < 10'h100 || v[k] > 10'h200 : 1'b0;
                wr(5'h04, 8'(m));
                wr(5'h0A, m == 4 ? 8'h00 : 8'h03);
                level <= v[k];
                conv();
                rd(5'h0B, q);
                chk(q, {6'h00, e, 1'b1});
                chk(window_irq_o, e && m != 4);
                chk(ready_irq_o, m != 4);
                wr(5'h0B, 8'h00);
                rd(5'h0B, q);
                chk(q, {6'h00, e, 1'b1});
                wr(5'h0B, 8'h03);
                rd(5'h0B, q);
                chk(q, 8'h00);
            end
        wr(5'h04, 8'h00);
        $display("t_window done");
    endtask
    task automatic t_accum();
        logic [7:0]  mc [4] = '{8'h01, 8'h05, 8'h01, 8'h01};
        logic [2:0]  cd [4] = '{3'h6, 3'h1, 3'h0, 3'h2};
        logic [9:0]  lv [4] = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h000};
        logic [15:0] ex [4] = '{16'hFFC0, 16'h01FE, 16'h03FF, 16'h0000};
        logic [7:0]  lo, hi;
        wr(5'h0A, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h00, mc[i]);
            wr(5'h01, {5'h00, cd[i]});
            level <= lv[i];
            conv();
            rd(5'h10, lo);
            rd(5'h11, hi);
            chk({hi, lo}, ex[i]);
            rd(5'h0D, lo);
            chk(lo, ex[i][15:8]);
            rd(5'h0B, lo);
            chk(lo, 8'h00);
        end
        wr(5'h01, 8'h00);
        wr(5'h03, 8'h1F);
        conv();
        rd(5'h03, lo);
        chk(lo, 8'h10);
        wr(5'h03, 8'h03);
        conv();
        rd(5'h03, lo);
        chk(lo, 8'h03);
        $display("t_accum done");
    endtask
    task automatic t_mux();
        logic [15:0] c = count;
        lat <= 4'h6;
        wr(5'h06, 8'h05);
        wr(5'h05, 8'h08);
        wr(5'h08, 8'h01);
        wr(5'h06, 8'h1F);
        wr(5'h08, 8'h01);
        wait_idle(1'b1);
        chk(seen, 5'h05);
        chk(count - c, 16'h0001);
        conv();
        chk(seen, 5'h1F);
        wr(5'h05, 8'h04);
        lat <= 4'h1;
        $display("t_mux done");
    endtask
    task automatic t_event();
        logic [7:0]  q;
        logic [15:0] c;
        wr(5'h09, 8'h01);
        pulse();
        wait_idle(1'b1);
        rd(5'h0B, q);
        chk(q[0], 1'b1);
        debug_halt_i <= 1'b1;
        c = count;
        repeat (4) @(posedge clk_i);
        pulse();
        repeat (40) @(posedge clk_i);
        chk(count - c, 16'h0000);
        wr(5'h0C, 8'h01);
        pulse();
        wait_idle(1'b1);
        chk(count - c, 16'h0001);
        debug_halt_i <= 1'b0;
        wr(5'h09, 8'h00);
        $display("t_event done");
    endtask
    task automatic t_cont();
        logic [15:0] c = count;
        int n = 0;
        wr(5'h00, 8'h03);
        wr(5'h08, 8'h01);
        while (count - c < 16'h0003 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(16'(n < 2000), 16'h0001);
        wr(5'h00, 8'h01);
        wait_idle(1'b0);
        $display("t_cont done");
    endtask

    // ----------------
    // sequence
    // ----------------
    initial
        forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_window();
        t_accum();
        t_mux();
        t_event();
        t_cont();
        end_sim();
    end
endmodule

bind adc_control adc_control_properties i_adc_control_properties (.clk_i(clk_i),
    .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .input_select_o(input_select_o),
    .sample_open_o(sample_open_o), .convert_start_o(convert_start_o),
    .ready_irq_o(ready_irq_o), .window_irq_o(window_irq_o));
